//--- inc/lvd_ctrl_pkg.sv
// Purpose: Constants for the supply monitor status and control block.
// Assumes: Avalon-MM slave with 32-bit data and byte addressing.
// Notes: Offsets are byte addresses of aligned words.
package lvd_ctrl_pkg;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 4'hC;
  localparam int BIT_WARN_FLAG = 7;
  localparam int BIT_WARN_ACK = 6;
  localparam int BIT_WARN_IE = 5;
  localparam int BIT_RST_EN = 4;
  localparam int BIT_STOP_EN = 3;
  localparam int BIT_DET_EN = 2;
  localparam int BIT_UNUSED = 1;
  localparam int BIT_BGB_EN = 0;
  localparam int EVT_WARN = 0;
  localparam int EVT_DETECT = 1;
  localparam int NUM_EVT = 2;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;
endpackage

//--- rtl/low_voltage_detect_control.sv
// Purpose: Supply warning flag, undervoltage detect control and bandgap
//   buffer enable, reached over an Avalon-MM slave.
// Assumes: Comparator inputs are asynchronous to i_clk.
// Notes: Reads wait one cycle so read data leaves a flip-flop; writes
//   never wait.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Warning flag bit 7 sets with condition and sticks until acknowledged.
// - Flag sets on falling below trip point, also at reset release.
// - Writing 1 to bit 6 clears flag only when condition has gone.
// - With bit 5 set, flag raises interrupt request; otherwise poll only.
// - Bit 4 with detect enabled makes a detect event request reset.
// - Bit 3 keeps detection active in stop mode; freely read/write.
// - Bit 2 enables detect logic and qualifies bits 4 and 3.
// - Bits 2 and 4 accept only the first write after reset.
// - Bit 0 drives the bandgap reference buffer enable.
module low_voltage_detect_control
  import lvd_ctrl_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_warn_cmp,
  input wire logic i_detect_cmp,
  input wire logic i_stop_mode,
  output logic o_warn_irq,
  output logic o_reset_req,
  output logic o_bandgap_buffer_enable,
  output logic o_irq
);

  logic supply_warning_flag_r;
  logic supply_warning_irq_enable_r;
  logic undervoltage_reset_enable_r;
  logic undervoltage_stop_enable_r;
  logic undervoltage_detect_enable_r;
  logic bandgap_buffer_enable_r;
  logic once_locked_r;
  logic reset_req_r;
  logic [NUM_EVT-1:0] evt_status_r;
  logic [NUM_EVT-1:0] evt_enable_r;
  logic [31:0] readdata_r;
  logic rd_done_r;

  wire [NUM_EVT-1:0] cmp_pin = {i_detect_cmp, i_warn_cmp};
  wire [NUM_EVT-1:0] cmp_level;

  // The first stage may go metastable; a change counts only once the second
  // and third stages agree, which also keeps one-cycle glitches out.
  for (genvar g = 0; g < NUM_EVT; g = g + 1) begin : g_sync
    logic [2:0] stage_r;
    logic level_r;
    always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
        stage_r <= 3'h0;
        level_r <= 1'b0;
      end else begin
        stage_r <= {stage_r[1:0], cmp_pin[g]};
        if (stage_r[1] == stage_r[2]) begin
          level_r <= stage_r[2];
        end
      end
    end
    assign cmp_level[g] = level_r;
  end
  wire warn_level = cmp_level[EVT_WARN];
  wire det_level = cmp_level[EVT_DETECT];

  // One decoder serves every write strobe, so the lane and address rules
  // live in a single place.
  function automatic logic lane0_write(input logic wr,
                                       input logic [3:0] be,
                                       input logic [ADDR_W-1:0] adr,
                                       input logic [ADDR_W-1:0] off);
    return wr && be[0] && (adr == off);
  endfunction

  wire wr_ctrl = lane0_write(i_avs_write, i_avs_byteenable,
    i_avs_address, OFF_CTRL);
  wire wr_clr = lane0_write(i_avs_write, i_avs_byteenable,
    i_avs_address, OFF_IRQ_CLEAR);
  wire wr_ien = lane0_write(i_avs_write, i_avs_byteenable,
    i_avs_address, OFF_IRQ_ENABLE);
  wire [7:0] wd = i_avs_writedata[7:0];

  // Detection active only when enabled, and in stop only with stop enable.
  wire detect_active = undervoltage_detect_enable_r &&
    (!i_stop_mode || undervoltage_stop_enable_r);
  wire detect_event = detect_active && det_level;
  wire warn_present = warn_level;
  wire ack_clear = wr_ctrl && wd[BIT_WARN_ACK] && !warn_present;

  wire [7:0] ctrl_view = {supply_warning_flag_r, 1'b0,
    supply_warning_irq_enable_r, undervoltage_reset_enable_r,
    undervoltage_stop_enable_r, undervoltage_detect_enable_r,
    1'b0, bandgap_buffer_enable_r};

  wire [NUM_EVT-1:0] evt_set = {detect_event, warn_present};
  wire [NUM_EVT-1:0] evt_clr = wr_clr ? wd[NUM_EVT-1:0] : '0;

  // The flag input is the synchronised comparator, so a supply already low
  // at reset release sets the flag within the synchroniser delay.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      supply_warning_flag_r <= CTRL_RESET[BIT_WARN_FLAG];
      supply_warning_irq_enable_r <= CTRL_RESET[BIT_WARN_IE];
      undervoltage_reset_enable_r <= CTRL_RESET[BIT_RST_EN];
      undervoltage_stop_enable_r <= CTRL_RESET[BIT_STOP_EN];
      undervoltage_detect_enable_r <= CTRL_RESET[BIT_DET_EN];
      bandgap_buffer_enable_r <= CTRL_RESET[BIT_BGB_EN];
      once_locked_r <= 1'b0;
    end else begin
      if (warn_present) begin
        supply_warning_flag_r <= 1'b1;
      end else if (ack_clear) begin
        supply_warning_flag_r <= 1'b0;
      end
      if (wr_ctrl) begin
        supply_warning_irq_enable_r <= wd[BIT_WARN_IE];
        undervoltage_stop_enable_r <= wd[BIT_STOP_EN];
        bandgap_buffer_enable_r <= wd[BIT_BGB_EN];
        once_locked_r <= 1'b1;
        if (!once_locked_r) begin
          undervoltage_reset_enable_r <= wd[BIT_RST_EN];
          undervoltage_detect_enable_r <= wd[BIT_DET_EN];
        end
      end
    end
  end

  // Reset request is registered so it never glitches from decode logic.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      reset_req_r <= 1'b0;
    end else begin
      reset_req_r <= detect_event && undervoltage_reset_enable_r;
    end
  end

  // Hardware set beats a software clear in the same cycle.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      evt_status_r <= '0;
      evt_enable_r <= '0;
    end else begin
      evt_status_r <= (evt_status_r & ~evt_clr) | evt_set;
      if (wr_ien) begin
        evt_enable_r <= wd[NUM_EVT-1:0];
      end
    end
  end

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = UNMAPPED_DATA;
    case (i_avs_address)
      OFF_CTRL: rd_mux = {24'h000000, ctrl_view};
      OFF_IRQ_STATUS: rd_mux = {{(32-NUM_EVT){1'b0}}, evt_status_r};
      OFF_IRQ_ENABLE: rd_mux = {{(32-NUM_EVT){1'b0}}, evt_enable_r};
      default: rd_mux = UNMAPPED_DATA;
    endcase
  end

  // Reads take one wait cycle so read data comes from a flip-flop; the word
  // returned is the register state one cycle before the answer.
  wire rd_start = i_avs_read && !rd_done_r;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      readdata_r <= UNMAPPED_DATA;
      rd_done_r <= 1'b0;
    end else begin
      rd_done_r <= rd_start;
      if (rd_start) begin
        readdata_r <= rd_mux;
      end
    end
  end

  assign o_avs_readdata = readdata_r;
  assign o_avs_waitrequest = rd_start;
  assign o_warn_irq = supply_warning_flag_r && supply_warning_irq_enable_r;
  assign o_reset_req = reset_req_r;
  assign o_bandgap_buffer_enable = bandgap_buffer_enable_r;
  assign o_irq = |(evt_status_r & evt_enable_r);

  property p_flag_sticks;
    @(posedge i_clk) disable iff (!i_reset_n)
      supply_warning_flag_r && !ack_clear |=> supply_warning_flag_r;
  endproperty
  a_flag_sticks: assert property (p_flag_sticks)
    else $error("Warning flag dropped without acknowledge.");

  property p_flag_sets;
    @(posedge i_clk) disable iff (!i_reset_n)
      warn_present |=> supply_warning_flag_r;
  endproperty
  a_flag_sets: assert property (p_flag_sets)
    else $error("Warning flag not set by warning condition.");

  property p_ack_blocked;
    @(posedge i_clk) disable iff (!i_reset_n)
      warn_present && wr_ctrl && wd[BIT_WARN_ACK] |=> supply_warning_flag_r;
  endproperty
  a_ack_blocked: assert property (p_ack_blocked)
    else $error("Acknowledge cleared flag while warning present.");

  property p_ack_clears;
    @(posedge i_clk) disable iff (!i_reset_n)
      ack_clear |=> !supply_warning_flag_r;
  endproperty
  a_ack_clears: assert property (p_ack_clears)
    else $error("Acknowledge failed to clear flag.");

  property p_warn_irq;
    @(posedge i_clk) disable iff (!i_reset_n)
      o_warn_irq == (ctrl_view[BIT_WARN_FLAG] && ctrl_view[BIT_WARN_IE]);
  endproperty
  a_warn_irq: assert property (p_warn_irq)
    else $error("Warning interrupt does not follow flag and enable.");

  property p_reset_cause;
    @(posedge i_clk) disable iff (!i_reset_n)
      o_reset_req |-> $past(undervoltage_reset_enable_r) &&
        $past(undervoltage_detect_enable_r) && $past(det_level);
  endproperty
  a_reset_cause: assert property (p_reset_cause)
    else $error("Reset request without enabled detect event.");

  property p_stop_gate;
    @(posedge i_clk) disable iff (!i_reset_n)
      i_stop_mode && !undervoltage_stop_enable_r |=> !o_reset_req;
  endproperty
  a_stop_gate: assert property (p_stop_gate)
    else $error("Detection acted in stop mode while disabled.");

  property p_once;
    @(posedge i_clk) disable iff (!i_reset_n)
      once_locked_r |=> $stable(undervoltage_detect_enable_r) &&
        $stable(undervoltage_reset_enable_r);
  endproperty
  a_once: assert property (p_once)
    else $error("Write-once bit changed after lock.");

  property p_bgb;
    @(posedge i_clk) disable iff (!i_reset_n)
      wr_ctrl |=> o_bandgap_buffer_enable == $past(wd[BIT_BGB_EN]);
  endproperty
  a_bgb: assert property (p_bgb)
    else $error("Bandgap enable did not take written value.");

  property p_bit1_zero;
    @(posedge i_clk) disable iff (!i_reset_n)
      i_avs_read && !o_avs_waitrequest && i_avs_address == OFF_CTRL |->
        !o_avs_readdata[BIT_UNUSED];
  endproperty
  a_bit1_zero: assert property (p_bit1_zero)
    else $error("Unused bit read as one.");

  property p_set_wins;
    @(posedge i_clk) disable iff (!i_reset_n)
      evt_set != '0 |=> (evt_status_r & $past(evt_set)) == $past(evt_set);
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("Event clear overrode a set in the same cycle.");

  property p_read_wait;
    @(posedge i_clk) disable iff (!i_reset_n)
      i_avs_read && o_avs_waitrequest |=> !o_avs_waitrequest;
  endproperty
  a_read_wait: assert property (p_read_wait)
    else $error("Read held off for more than one cycle.");

  property p_write_nowait;
    @(posedge i_clk) disable iff (!i_reset_n)
      i_avs_write |-> !o_avs_waitrequest;
  endproperty
  a_write_nowait: assert property (p_write_nowait)
    else $error("Write was held off.");

  property p_detect_gate;
    @(posedge i_clk) disable iff (!i_reset_n)
      !undervoltage_detect_enable_r |=> !o_reset_req;
  endproperty
  a_detect_gate: assert property (p_detect_gate)
    else $error("Reset requested with detection disabled.");

  property p_reset_gate;
    @(posedge i_clk) disable iff (!i_reset_n)
      !undervoltage_reset_enable_r |=> !o_reset_req;
  endproperty
  a_reset_gate: assert property (p_reset_gate)
    else $error("Reset requested with detect reset disabled.");

  c_ack: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    supply_warning_flag_r ##1 !supply_warning_flag_r);
  c_reset: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    o_reset_req);
  c_irq: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    o_warn_irq);
  c_stop_detect: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    i_stop_mode && o_reset_req);
  c_event_irq: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    o_irq);

endmodule

`default_nettype wire

//--- testbench/low_voltage_detect_control_tb_top.sv
// Purpose: Self-checking bench for the supply monitor control block.
// Assumes: Comparator effects settle within 8 clocks.
// Notes: The driver queues expected read data and a monitor checks it.
`timescale 1ns/1ps
`default_nettype none
module low_voltage_detect_control_tb_top
  import lvd_ctrl_pkg::*;
;
  logic i_clk, i_reset_n, rd, wr, warn, det, stp;
  logic [ADDR_W-1:0] adr;
  logic [31:0] wd, seed, rdat;
  logic [3:0] be;
  logic wt, wirq, rreq, bgb, irq;
  logic [31:0] exp_q[$];
  int miscompares, n_tests;
  logic [7:0] d;
  low_voltage_detect_control uut (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wt), .i_warn_cmp(warn), .i_detect_cmp(det),
    .i_stop_mode(stp), .o_warn_irq(wirq), .o_reset_req(rreq),
    .o_bandgap_buffer_enable(bgb), .o_irq(irq));
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] ex);
    n_tests++;
    if (seen !== ex) begin
      miscompares++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, ex);
    end
  endtask
  task automatic stop_test;
    if (miscompares == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Each access starts one edge after the last so no signal moves twice.
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [7:0] v, input logic [7:0] e);
    int k;
    @(posedge i_clk);
    if (!w) exp_q.push_back({24'h000000, e});
    adr <= a;
    wd <= {24'h000000, v};
    wr <= w;
    rd <= !w;
    for (k = 0; k < 16; k++) begin
      @(posedge i_clk);
      if (wt === 1'b0) break;
    end
    if (k == 16) begin
      miscompares++;
      stop_test();
    end
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic lvl(input int n, input logic [3:0] e);
    repeat (n) @(posedge i_clk);
    @(negedge i_clk);
    check({28'h0000000, wirq, rreq, bgb, irq}, {28'h0000000, e});
    // Return on a rising edge so the next input change is launched there.
    @(posedge i_clk);
  endtask
  always @(posedge i_clk) begin
    if (rd === 1'b1 && wt === 1'b0) begin
      if (exp_q.size() > 0)
        check(rdat, exp_q.pop_front());
      else
        check(rdat, 32'hFFFFFFFF);
    end
  end
  initial begin
    {i_reset_n, rd, wr, warn, det, stp} = 6'h00;
    adr = 4'h0;
    wd = 32'h00000000;
    be = 4'h1;
    seed = 32'h0693C4F0;
    miscompares = 0;
    n_tests = 0;
    repeat (8) @(posedge i_clk);
    i_reset_n <= 1'b1;
    bus(0, OFF_CTRL, 8'h00, 8'h00);
    bus(0, 4'h2, 8'h00, 8'h00);
    bus(0, OFF_IRQ_CLEAR, 8'h00, 8'h00);
    bus(1, OFF_CTRL, 8'h7F, 8'h00);
    bus(0, OFF_CTRL, 8'h00, 8'h3D);
    lvl(1, 4'b0010);
    bus(1, OFF_CTRL, 8'h00, 8'h00);
    bus(0, OFF_CTRL, 8'h00, 8'h14);
    bus(1, OFF_IRQ_ENABLE, 8'h03, 8'h00);
    det <= 1'b1;
    lvl(8, 4'b0101);
    stp <= 1'b1;
    lvl(8, 4'b0001);
    bus(1, OFF_CTRL, 8'h08, 8'h00);
    lvl(8, 4'b0101);
    det <= 1'b0;
    stp <= 1'b0;
    lvl(8, 4'b0001);
    bus(1, OFF_IRQ_CLEAR, 8'h03, 8'h00);
    lvl(1, 4'b0000);
    warn <= 1'b1;
    bus(0, OFF_CTRL, 8'h00, 8'h1C);
    lvl(8, 4'b0001);
    bus(0, OFF_CTRL, 8'h00, 8'h9C);
    lvl(1, 4'b0001);
    bus(1, OFF_CTRL, 8'h68, 8'h00);
    bus(0, OFF_CTRL, 8'h00, 8'hBC);
    lvl(1, 4'b1001);
    warn <= 1'b0;
    lvl(8, 4'b1001);
    bus(0, OFF_CTRL, 8'h00, 8'hBC);
    bus(1, OFF_CTRL, 8'h68, 8'h00);
    bus(0, OFF_CTRL, 8'h00, 8'h3C);
    bus(0, OFF_IRQ_STATUS, 8'h00, 8'h01);
    bus(1, OFF_IRQ_ENABLE, 8'h00, 8'h00);
    lvl(1, 4'b0000);
    bus(1, OFF_IRQ_CLEAR, 8'h03, 8'h00);
    bus(1, OFF_IRQ_ENABLE, 8'h03, 8'h00);
    lvl(1, 4'b0000);
    repeat (6) begin
      seed = lfsr(seed);
      d = seed[7:0];
      bus(1, OFF_CTRL, d, 8'h00);
      bus(0, OFF_CTRL, 8'h00, 8'h14 | (d & 8'h29));
      lvl(1, {2'b00, d[0], 1'b0});
    end
    // A reset with the warning held must leave the flag set on release.
    warn <= 1'b1;
    i_reset_n <= 1'b0;
    lvl(2, 4'b0000);
    i_reset_n <= 1'b1;
    repeat (8) @(posedge i_clk);
    bus(0, OFF_CTRL, 8'h00, 8'h80);
    bus(1, OFF_CTRL, 8'h00, 8'h00);
    bus(1, OFF_CTRL, 8'h14, 8'h00);
    bus(0, OFF_CTRL, 8'h00, 8'h80);
    det <= 1'b1;
    lvl(8, 4'b0000);
    stop_test();
  end
endmodule
`default_nettype wire
